// file: design/vmeir_defs.vh
// Constants for the backplane interrupt requester: register map, field
// positions, reset values and selector codes.
// Assumes it is included by bare name from the requester's design files.
`ifndef VMEIR_DEFS_VH
`define VMEIR_DEFS_VH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define VMEIR_CTRL_ADDR 32'hfff40048
`define VMEIR_RD_ZERO 32'h00000000

// ----------------------------------------------------------------------
// Control byte fields, bits 31..24 of the word
// ----------------------------------------------------------------------
`define VMEIR_SEL_MSB 31
`define VMEIR_SEL_LSB 30
`define VMEIR_WDRAW_BIT 28
`define VMEIR_PEND_BIT 27
`define VMEIR_LVL_MSB 26
`define VMEIR_LVL_LSB 24

// ----------------------------------------------------------------------
// Vector byte, bits 23..16 of the word
// ----------------------------------------------------------------------
`define VMEIR_VEC_MSB 23
`define VMEIR_VEC_LSB 16
`define VMEIR_VEC_RST 8'h0f

// ----------------------------------------------------------------------
// Field values
// ----------------------------------------------------------------------
`define VMEIR_LVL_NONE 3'h0
`define VMEIR_LVL_BCAST 3'h1
`define VMEIR_SEL_RST 2'h0
`define VMEIR_SEL_OWN0 2'h0
`define VMEIR_SEL_TICK1 2'h1
`define VMEIR_SEL_OWN2 2'h2
`define VMEIR_SEL_TICK2 2'h3

// ----------------------------------------------------------------------
// Pin synchroniser
// ----------------------------------------------------------------------
`define VMEIR_SYNC_W 7
`define VMEIR_SYNC_RST 7'h7f

`endif

// file: design/vmeir_sync.v
// Two-flop synchroniser for a group of backplane input pins.
// Assumes each bit is an independent level; no multi-bit coherence.
`timescale 1ns/1ps

module vmeir_sync #(
	parameter WIDTH = 7,
	parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b1}}
) (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Asynchronous levels in
	input wire [WIDTH-1:0] async_in,
	// Levels in the clk domain
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_r;
	reg [WIDTH-1:0] sync_r;

	// ------------------------------------------------------------------
	// Two stages; the first is read only by the second
	// ------------------------------------------------------------------
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta_r <= RST_VAL;
			sync_r <= RST_VAL;
		end
		else
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;

endmodule

// file: design/vmeir_requester.v
// Backplane interrupt requester: control and vector registers on a plain
// register port, seven open-drain request lines and the acknowledge cycle.
// Assumes backplane pins are asynchronous and tick inputs are on clk.
`timescale 1ns/1ps
`include "vmeir_defs.vh"

module vmeir_requester (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Register port
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output wire [31:0] reg_rdata,
	// Tick timer outputs, same clock
	input wire tick1_out,
	input wire tick2_out,
	// Request lines 7..1, open drain, active low
	output wire [7:1] irq_n_o,
	output wire [7:1] irq_n_oe,
	// Acknowledge cycle inputs from the backplane
	input wire as_n_i,
	input wire iack_n_i,
	input wire iackin_n_i,
	input wire ds0_n_i,
	input wire [3:1] vme_addr_i,
	// Acknowledge cycle outputs to the backplane
	output wire [7:0] data_o,
	output wire data_oe,
	output wire dtack_n_o,
	output wire dtack_n_oe,
	output wire iackout_n_o,
	// Local status
	output wire pending
);

	// ------------------------------------------------------------------
	// Acknowledge states
	// ------------------------------------------------------------------
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_DRIVE = 3'h1;
	localparam [2:0] S_DTACK = 3'h2;
	localparam [2:0] S_DONE = 3'h3;
	localparam [2:0] S_PASS = 3'h4;
	localparam [2:0] S_WAIT = 3'h5;

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------
	// One line per level; level zero drives nothing
	function [7:1] lvl_lines;
		input [2:0] lvl;
		integer i;
		begin
			lvl_lines = 7'h00;
			for (i = 1; i < 8; i = i + 1)
			begin
				if (lvl == i[2:0])
					lvl_lines[i] = 1'b1;
			end
		end
	endfunction

	// True when an acknowledge is for a level we are holding
	function ack_is_ours;
		input [2:0] ack_lvl;
		input [2:0] own_lvl;
		input own_pend;
		input line_ours;
		begin
			ack_is_ours = own_pend && line_ours && (ack_lvl == own_lvl) &&
				(own_lvl != `VMEIR_LVL_NONE);
		end
	endfunction

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	reg [2:0] lvl_r;
	reg [2:0] lvl_nxt;
	reg pend_r;
	reg pend_nxt;
	reg [1:0] sel_r;
	reg [1:0] sel_nxt;
	reg [7:0] vec_r;
	reg [7:0] vec_nxt;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	reg [7:1] irq_oe_r;
	reg [7:1] irq_oe_nxt;
	reg [2:0] state_r;
	reg [2:0] state_nxt;
	reg [7:0] dout_r;
	reg [7:0] dout_nxt;
	reg dout_oe_r;
	reg dout_oe_nxt;
	reg dtack_oe_r;
	reg dtack_oe_nxt;
	reg iackout_n_r;
	reg iackout_n_nxt;
	reg ack_clear;
	reg line1_own;
	wire [`VMEIR_SYNC_W-1:0] pins_sync;
	wire as_n_s;
	wire iack_n_s;
	wire iackin_n_s;
	wire ds0_n_s;
	wire [2:0] ack_lvl_s;
	wire ctrl_hit;
	wire wr_hit;
	wire [2:0] wr_lvl;
	wire wr_wdraw;
	wire ack_start;
	wire ack_abort;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	vmeir_sync #(
		.WIDTH(`VMEIR_SYNC_W),
		.RST_VAL(`VMEIR_SYNC_RST)
	) u_sync (
		.clk(clk),
		.sys_rst(sys_rst),
		.async_in({as_n_i, iack_n_i, iackin_n_i, ds0_n_i, vme_addr_i}),
		.sync_out(pins_sync)
	);

	assign as_n_s = pins_sync[6];
	assign iack_n_s = pins_sync[5];
	assign iackin_n_s = pins_sync[4];
	assign ds0_n_s = pins_sync[3];
	assign ack_lvl_s = pins_sync[2:0];

	// ------------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------------
	assign ctrl_hit = (reg_addr == `VMEIR_CTRL_ADDR);
	assign wr_hit = reg_wr && ctrl_hit;
	assign wr_lvl = reg_wdata[`VMEIR_LVL_MSB:`VMEIR_LVL_LSB];
	assign wr_wdraw = reg_wdata[`VMEIR_WDRAW_BIT];

	// ------------------------------------------------------------------
	// Request, pending, selector and vector
	// ------------------------------------------------------------------
	always @*
	begin
		lvl_nxt = lvl_r;
		pend_nxt = pend_r;
		sel_nxt = sel_r;
		vec_nxt = vec_r;
		// Acknowledge completion drops the request
		if (ack_clear)
		begin
			lvl_nxt = `VMEIR_LVL_NONE;
			pend_nxt = 1'b0;
		end
		if (wr_hit)
		begin
			sel_nxt = reg_wdata[`VMEIR_SEL_MSB:`VMEIR_SEL_LSB];
			vec_nxt = reg_wdata[`VMEIR_VEC_MSB:`VMEIR_VEC_LSB];
			// A zero in the withdraw bit changes nothing
			if (wr_wdraw)
			begin
				lvl_nxt = `VMEIR_LVL_NONE;
				pend_nxt = 1'b0;
			end
			// A new level wins over withdraw and acknowledge in one cycle
			if (wr_lvl != `VMEIR_LVL_NONE)
			begin
				lvl_nxt = wr_lvl;
				pend_nxt = 1'b1;
			end
		end
	end

	// ------------------------------------------------------------------
	// Line 1 routing and request line drive
	// ------------------------------------------------------------------
	always @*
	begin
		irq_oe_nxt = lvl_lines(lvl_r);
		line1_own = 1'b1;
		case (sel_r)
			`VMEIR_SEL_OWN0:
			begin
				line1_own = 1'b1;
			end
			`VMEIR_SEL_OWN2:
			begin
				line1_own = 1'b1;
			end
			`VMEIR_SEL_TICK1:
			begin
				line1_own = 1'b0;
				irq_oe_nxt[1] = tick1_out;
			end
			`VMEIR_SEL_TICK2:
			begin
				line1_own = 1'b0;
				irq_oe_nxt[1] = tick2_out;
			end
			default:
			begin
				line1_own = 1'b1;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Register read, data one cycle after the strobe
	// ------------------------------------------------------------------
	always @*
	begin
		rdata_nxt = `VMEIR_RD_ZERO;
		if (reg_rd && ctrl_hit)
		begin
			rdata_nxt[`VMEIR_SEL_MSB:`VMEIR_SEL_LSB] = sel_r;
			rdata_nxt[`VMEIR_PEND_BIT] = pend_r;
			rdata_nxt[`VMEIR_VEC_MSB:`VMEIR_VEC_LSB] = vec_r;
			// Level field and withdraw bit stay zero
		end
	end

	// ------------------------------------------------------------------
	// Acknowledge cycle
	// ------------------------------------------------------------------
	assign ack_start = !as_n_s && !iack_n_s && !iackin_n_s && !ds0_n_s;
	assign ack_abort = as_n_s || iackin_n_s;

	always @*
	begin
		state_nxt = state_r;
		dout_nxt = dout_r;
		dout_oe_nxt = 1'b0;
		dtack_oe_nxt = 1'b0;
		iackout_n_nxt = 1'b1;
		ack_clear = 1'b0;
		case (state_r)
			S_IDLE:
			begin
				if (ack_start)
				begin
					if (ack_is_ours(ack_lvl_s, lvl_r, pend_r,
						(lvl_r != `VMEIR_LVL_BCAST) || line1_own))
					begin
						dout_nxt = vec_r;
						dout_oe_nxt = 1'b1;
						state_nxt = S_DRIVE;
					end
					else
					begin
						iackout_n_nxt = 1'b0;
						state_nxt = S_PASS;
					end
				end
			end
			S_DRIVE:
			begin
				// Data settle one cycle ahead of the strobe
				dout_oe_nxt = 1'b1;
				dtack_oe_nxt = 1'b1;
				state_nxt = S_DTACK;
			end
			S_DTACK:
			begin
				dout_oe_nxt = 1'b1;
				dtack_oe_nxt = 1'b1;
				if (ds0_n_s || as_n_s)
				begin
					dout_oe_nxt = 1'b0;
					dtack_oe_nxt = 1'b0;
					state_nxt = S_DONE;
				end
			end
			S_DONE:
			begin
				ack_clear = 1'b1;
				state_nxt = S_WAIT;
			end
			S_PASS:
			begin
				iackout_n_nxt = 1'b0;
				if (ack_abort)
				begin
					iackout_n_nxt = 1'b1;
					state_nxt = S_IDLE;
				end
			end
			S_WAIT:
			begin
				// Hold off until the cycle ends so one cycle answers once
				if (as_n_s)
					state_nxt = S_IDLE;
			end
			default:
			begin
				state_nxt = S_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------------
	always @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			lvl_r <= `VMEIR_LVL_NONE;
			pend_r <= 1'b0;
			sel_r <= `VMEIR_SEL_RST;
			vec_r <= `VMEIR_VEC_RST;
			rdata_r <= `VMEIR_RD_ZERO;
			irq_oe_r <= 7'h00;
			state_r <= S_IDLE;
			dout_r <= 8'h00;
			dout_oe_r <= 1'b0;
			dtack_oe_r <= 1'b0;
			iackout_n_r <= 1'b1;
		end
		else
		begin
			lvl_r <= lvl_nxt;
			pend_r <= pend_nxt;
			sel_r <= sel_nxt;
			vec_r <= vec_nxt;
			rdata_r <= rdata_nxt;
			irq_oe_r <= irq_oe_nxt;
			state_r <= state_nxt;
			dout_r <= dout_nxt;
			dout_oe_r <= dout_oe_nxt;
			dtack_oe_r <= dtack_oe_nxt;
			iackout_n_r <= iackout_n_nxt;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign reg_rdata = rdata_r;
	assign irq_n_o = 7'h00;
	assign irq_n_oe = irq_oe_r;
	assign data_o = dout_r;
	assign data_oe = dout_oe_r;
	assign dtack_n_o = 1'b0;
	assign dtack_n_oe = dtack_oe_r;
	assign iackout_n_o = iackout_n_r;
	assign pending = pend_r;

endmodule

// file: dv/vmeir_requester_assertions.sv
// Checker for the backplane interrupt requester, bound to its top module.
// Assumes one clock domain and the register map of vmeir_defs.vh.
`timescale 1ns/1ps
`include "vmeir_defs.vh"

module vmeir_requester_assertions (
	// Clock and reset
	input wire clk,
	input wire sys_rst,
	// Register port
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Ticks and backplane
	input wire tick1_out,
	input wire tick2_out,
	input wire [7:1] irq_n_oe,
	input wire [7:0] data_o,
	input wire data_oe,
	input wire dtack_n_oe,
	input wire pending
);
	reg [1:0] sel_r;
	reg [7:0] vec_r;
	wire wr_hit = reg_wr && reg_addr == `VMEIR_CTRL_ADDR;
	wire [2:0] lvl = reg_wdata[26:24];

	// Shadow of selector and vector
	always @(posedge clk or posedge sys_rst)
		if (sys_rst)
		begin
			sel_r <= 2'h0;
			vec_r <= 8'h0f;
		end
		else if (wr_hit)
		begin
			sel_r <= reg_wdata[31:30];
			vec_r <= reg_wdata[23:16];
		end

	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	sequence s_lvl3_wr;
		wr_hit && lvl == 3'h3;
	endsequence
	sequence s_answer;
		data_oe ##1 (data_oe && dtack_n_oe);
	endsequence

	a_level_drives_line: assert property (s_lvl3_wr |-> ##2 irq_n_oe[3])
		else $error("level write left its line idle");
	a_write_sets_pend: assert property (wr_hit && lvl != 3'h0 |=> pending)
		else $error("level write did not set pending");
	a_zero_keeps_pend: assert property (
		wr_hit && lvl == 3'h0 && !reg_wdata[28] && pending |=> pending)
		else $error("zero write changed pending");
	a_fields_read_zero: assert property (
		reg_rd |=> reg_rdata[28] == 1'b0 && reg_rdata[26:24] == 3'h0)
		else $error("write-only field read nonzero");
	a_withdraw_drops: assert property (
		wr_hit && reg_wdata[28] && lvl == 3'h0 |=> !pending ##1
		(irq_n_oe[7:2] == 6'h00 && (!irq_n_oe[1] || sel_r[0])))
		else $error("withdraw left request up");
	a_tick1_routed: assert property (
		sel_r == 2'h1 && $stable(sel_r) |=> irq_n_oe[1] == $past(tick1_out))
		else $error("line 1 not following tick 1");
	a_tick2_routed: assert property (
		sel_r == 2'h3 && $stable(sel_r) |=> irq_n_oe[1] == $past(tick2_out))
		else $error("line 1 not following tick 2");
	a_ack_order: assert property ($rose(data_oe) |-> s_answer)
		else $error("vector not followed by acknowledge");
	a_vector_out: assert property (data_oe |-> data_o == vec_r)
		else $error("wrong vector on data lines");
	a_ack_clears: assert property (
		$fell(dtack_n_oe) |-> ##[1:3] (!pending && irq_n_oe[7:2] == 6'h00))
		else $error("request not cleared after acknowledge");
endmodule

bind vmeir_requester vmeir_requester_assertions vmeir_requester_assertions_i (
	.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.tick1_out, .tick2_out, .irq_n_oe, .data_o, .data_oe, .dtack_n_oe, .pending
);

// file: dv/vmeir_handler_model.sv
// Backplane interrupt handler model: runs one acknowledge cycle.
// Assumes pulled-up strobe lines on the backplane.
`timescale 1ns/1ps

module vmeir_handler_model (
	// Clock
	input wire clk,
	// Acknowledge strobes and level
	output reg as_n,
	output reg iack_n,
	output reg iackin_n,
	output reg ds0_n,
	output reg [3:1] vme_addr,
	// Answer from the requester
	input wire [7:0] data_o,
	input wire dtack_n_oe,
	input wire iackout_n_o
);
	initial
	begin
		{as_n, iack_n, iackin_n, ds0_n} = 4'hf;
		vme_addr = 3'h0;
	end

	// resp: 1 vector taken, 2 passed on, 0 no answer
	task ack(input [2:0] l, input [3:0] hold, output [7:0] v, output [1:0] resp);
		integer i;
		begin
			v = 8'h00;
			resp = 2'h0;
			@(posedge clk);
			vme_addr <= l;
			{as_n, iack_n, iackin_n, ds0_n} <= 4'h0;
			// Answers are sampled mid-cycle, where they have settled
			for (i = 0; i < 20 && resp == 2'h0; i = i + 1)
			begin
				@(negedge clk);
				if (dtack_n_oe === 1'b1)
				begin
					v = data_o;
					resp = 2'h1;
				end
				else if (iackout_n_o === 1'b0)
					resp = 2'h2;
			end
			@(posedge clk);
			repeat (hold) @(posedge clk);
			// Strobes go to pull-up level, level lines change
			{as_n, iack_n, iackin_n, ds0_n} <= 4'hf;
			vme_addr <= ~l;
			repeat (8) @(posedge clk);
		end
	endtask
endmodule

// file: dv/vmeir_requester_bench.sv
// Self-checking bench for the backplane interrupt requester.
// Assumes the handler model drives the acknowledge pins.
`timescale 1ns/1ps
`include "vmeir_defs.vh"

module vmeir_requester_bench;
	reg clk, sys_rst, reg_wr, reg_rd, tick1_out, tick2_out;
	reg [31:0] reg_addr, reg_wdata, d;
	wire [31:0] reg_rdata;
	wire [7:1] irq_n_oe;
	wire [7:0] data_o;
	wire data_oe, dtack_n_oe, iackout_n_o, pending, as_n, iack_n, iackin_n, ds0_n;
	wire [3:1] vme_addr;
	wire [7:1] irq_n_o;
	wire dtack_n_o;
	integer errors, n_tests, s;
	reg [7:0] vec;
	reg [1:0] resp;

	vmeir_requester vmeir_requester_i (
		.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tick1_out(tick1_out),
		.tick2_out(tick2_out), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .as_n_i(as_n),
		.iack_n_i(iack_n), .iackin_n_i(iackin_n), .ds0_n_i(ds0_n), .vme_addr_i(vme_addr),
		.data_o(data_o), .data_oe(data_oe), .dtack_n_o(dtack_n_o), .dtack_n_oe(dtack_n_oe),
		.iackout_n_o(iackout_n_o), .pending(pending)
	);
	vmeir_handler_model vmeir_handler_model_i (
		.clk(clk), .as_n(as_n), .iack_n(iack_n), .iackin_n(iackin_n), .ds0_n(ds0_n),
		.vme_addr(vme_addr), .data_o(data_o), .dtack_n_oe(dtack_n_oe),
		.iackout_n_o(iackout_n_o)
	);

	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp)
			begin
				errors = errors + 1;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tally_and_finish;
		begin
			$display("errors %0d comparisons %0d", errors, n_tests);
			if (errors == 0 && n_tests > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	task wr(input [31:0] w);
		begin
			@(posedge clk);
			reg_addr <= `VMEIR_CTRL_ADDR;
			reg_wdata <= w;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [31:0] a);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(negedge clk);
			d = reg_rdata;
		end
	endtask
	task ack(input [2:0] l, input [3:0] hold, input [1:0] er, input [7:0] ev);
		begin
			vmeir_handler_model_i.ack(l, hold, vec, resp);
			if (resp === 2'h0)
			begin
				errors = errors + 1;
				tally_and_finish;
			end
			else
				chk({22'h0, resp, vec}, {22'h0, er, ev});
		end
	endtask

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial
	begin
		errors = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		tick1_out = 1'b0;
		tick2_out = 1'b0;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`VMEIR_CTRL_ADDR);
		chk(d, 32'h000f0000);
		rd(`VMEIR_CTRL_ADDR + 32'h4);
		chk(d, 32'h0);
		wr(32'h035a0000);
		rd(`VMEIR_CTRL_ADDR);
		chk(d, 32'h085a0000);
		chk({25'h0, irq_n_oe}, 32'h4);
		chk({24'h0, irq_n_o, dtack_n_o}, 32'h0);
		wr(32'h005a0000);
		rd(`VMEIR_CTRL_ADDR);
		chk(d, 32'h085a0000);
		ack(3'h5, 4'h0, 2'h2, 8'h00);
		ack(3'h3, 4'h5, 2'h1, 8'h5a);
		rd(`VMEIR_CTRL_ADDR);
		chk(d, 32'h005a0000);
		chk({25'h0, irq_n_oe}, 32'h0);
		wr(32'h010f0000);
		repeat (2) @(negedge clk);
		chk({25'h0, irq_n_oe}, 32'h1);
		wr(32'h100f0000);
		rd(`VMEIR_CTRL_ADDR);
		chk(d, 32'h000f0000);
		chk({25'h0, irq_n_oe}, 32'h0);
		for (s = 0; s < 4; s = s + 1)
		begin
			// Own level-1 request stays up, so only a tick selector may hide it
			wr({s[1:0], 30'h010f0000});
			tick1_out <= 1'b1;
			tick2_out <= 1'b0;
			repeat (3) @(negedge clk);
			chk({31'h0, irq_n_oe[1]}, {31'h0, s != 3});
			@(posedge clk);
			tick1_out <= 1'b0;
			tick2_out <= 1'b1;
			repeat (3) @(negedge clk);
			chk({31'h0, irq_n_oe[1]}, {31'h0, s != 1});
		end
		tally_and_finish;
	end
endmodule
